// ===== verilog/rssc_ctrl.sv
// Remote serial system command controller top level
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/10ps
module rssc_ctrl #(
  parameter int QDEPTH = 15,
  parameter logic [15:0] PASS_RST = 16'h0000
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_from_gpib_in,
  output logic [15:0] reg_rdata_out,
  // Serial pins
  input wire logic ser_rx_in,
  output logic ser_tx_out,
  // GPIB interface messages
  input wire logic gpib_msg_valid_in,
  input wire logic [7:0] gpib_msg_in,
  // Front panel and straps
  input wire logic knobs_both_in,
  input wire logic dip5_on_in,
  input wire logic lock_kept_in,
  output logic panel_enable_out,
  output logic remote_out,
  output logic lockout_display_code_out,
  // Command outcomes
  output logic prot_cmd_go_out,
  output logic legacy_accept_out,
  output logic exec_err_out
);
  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  localparam logic [3:0] QD = 4'(QDEPTH);
  rssc_pkg::rssc_cfg_t cfg_ff;
  rssc_pkg::rssc_cfg_t cfg_w;
  logic [15:0] q_mem_ff [QDEPTH];
  logic [3:0] q_rd_ff;
  logic [3:0] q_cnt_ff;
  logic [3:0] peek_ff;
  logic [15:0] pass_ff;
  logic prot_ff;
  logic echo_act_ff;
  logic lock_ff;
  logic remote_ff;
  logic paused_ff;
  logic [1:0] init_ff;
  logic knob_meta_ff;
  logic knob_sync_ff;
  logic knob_old_ff;
  logic dip_meta_ff;
  logic dip_sync_ff;
  logic kept_meta_ff;
  logic kept_sync_ff;
  logic echo_pend_ff;
  logic [7:0] echo_char_ff;
  logic prompt_pend_ff;
  logic sw_pend_ff;
  logic [7:0] sw_char_ff;
  logic rx_full_ff;
  logic [7:0] rx_hold_ff;
  logic [7:0] rx_char;
  logic rx_valid;
  logic tx_ready;
  logic tx_go;
  logic [7:0] tx_char;
  logic push;
  logic [15:0] push_code;
  logic pop;
  logic knob_rise;
  logic ctl_rx;

  // Refuse queue depths the 4-bit pointers cannot serve
  if (QDEPTH < 2 || QDEPTH > 15) begin : g_chk
    $error("QDEPTH must be 2 to 15");
  end

  // Circular queue index
  function automatic logic [3:0] qidx(input logic [3:0] base,
                                      input logic [3:0] off);
    logic [4:0] s;
    s = {1'b0, base} + {1'b0, off};
    if (s >= {1'b0, QD}) s = s - {1'b0, QD};
    qidx = s[3:0];
  endfunction

  // Register write decode
  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = reg_wr_in && (reg_addr_in == ofs);
  endfunction

  assign cfg_w = rssc_pkg::rssc_cfg_t'(reg_wdata_in[rssc_pkg::CFG_W-1:0]);

  // ------------------------------------------------------------------
  // Serial link
  // ------------------------------------------------------------------
  rssc_uart rssc_uart_i (
    .core_clk_in (core_clk_in),
    .rst_in (rst_in),
    .bit_div_in (rssc_pkg::baud_div(cfg_ff.baud)),
    .rx_pin_in (ser_rx_in),
    .tx_pin_out (ser_tx_out),
    .tx_char_in (tx_char),
    .tx_valid_in (tx_go),
    .tx_ready_out (tx_ready),
    .rx_char_out (rx_char),
    .rx_valid_out (rx_valid)
  );

  // Pacing characters are consumed, never stored or echoed
  assign ctl_rx = cfg_ff.pace && ((rx_char == rssc_pkg::CH_PAUSE)
                  || (rx_char == rssc_pkg::CH_RESUME));

  // Priority: echo, then prompt, then software data
  always_comb begin
    tx_char = sw_char_ff;
    if (echo_pend_ff) begin
      tx_char = echo_char_ff;
    end else if (prompt_pend_ff) begin
      tx_char = rssc_pkg::CH_PROMPT;
    end
  end
  assign tx_go = tx_ready && cfg_ff.txen && !paused_ff
                 && (echo_pend_ff || prompt_pend_ff || sw_pend_ff);

  // ------------------------------------------------------------------
  // Configuration
  // ------------------------------------------------------------------
  // Serial side cannot turn its own transmitter back on
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cfg_ff <= rssc_pkg::CFG_RST;
    end else if (wr_at(rssc_pkg::OFS_CFG)) begin
      cfg_ff <= cfg_w;
      cfg_ff.txen <= cfg_w.txen && (cfg_ff.txen || reg_from_gpib_in);
    end
  end

  // Echo stays active until the terminator after being switched off
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      echo_act_ff <= 1'b0;
    end else if (wr_at(rssc_pkg::OFS_CFG) && cfg_w.echo) begin
      echo_act_ff <= 1'b1;
    end else if (rx_valid && !cfg_ff.echo && rx_char == rssc_pkg::CH_TERM) begin
      echo_act_ff <= 1'b0;
    end
  end

  // Flow pause from the far end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      paused_ff <= 1'b0;
    end else if (rx_valid && ctl_rx) begin
      paused_ff <= (rx_char == rssc_pkg::CH_PAUSE);
    end else if (!cfg_ff.pace || wr_at(rssc_pkg::OFS_IRST)) begin
      paused_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Transmit sources; a disabled transmitter drops them
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      echo_pend_ff <= 1'b0;
      echo_char_ff <= '0;
    end else if (rx_valid && echo_act_ff && !ctl_rx && cfg_ff.txen) begin
      echo_pend_ff <= 1'b1;
      echo_char_ff <= rx_char;
    end else if (tx_go || !cfg_ff.txen) begin
      echo_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      prompt_pend_ff <= 1'b0;
    end else if (wr_at(rssc_pkg::OFS_DONE) && cfg_ff.prompt && cfg_ff.txen) begin
      prompt_pend_ff <= 1'b1;
    end else if ((tx_go && !echo_pend_ff) || !cfg_ff.txen) begin
      prompt_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sw_pend_ff <= 1'b0;
      sw_char_ff <= '0;
    end else if (wr_at(rssc_pkg::OFS_TXD) && !sw_pend_ff && cfg_ff.txen) begin
      sw_pend_ff <= 1'b1;
      sw_char_ff <= reg_wdata_in[7:0];
    end else if ((tx_go && !echo_pend_ff && !prompt_pend_ff) || !cfg_ff.txen) begin
      sw_pend_ff <= 1'b0;
    end
  end

  // Received character holding; a new one overwrites an unread one
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_full_ff <= 1'b0;
      rx_hold_ff <= '0;
    end else if (rx_valid && !ctl_rx) begin
      rx_full_ff <= 1'b1;
      rx_hold_ff <= rx_char;
    end else if (reg_rd_in && reg_addr_in == rssc_pkg::OFS_RXD) begin
      rx_full_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Error queue
  // ------------------------------------------------------------------
  // Reads and writes never share a cycle, so push and pop never meet
  always_comb begin
    push = 1'b1;
    push_code = reg_wdata_in;
    if (wr_at(rssc_pkg::OFS_PTRY) && reg_wdata_in != pass_ff) begin
      push_code = rssc_pkg::ERR_CONFLICT;
    end else if (wr_at(rssc_pkg::OFS_PCMD) && !prot_ff) begin
      push_code = rssc_pkg::ERR_PROTECTED;
    end else if (!wr_at(rssc_pkg::OFS_ERR)) begin
      push = 1'b0;
    end
  end
  assign pop = reg_rd_in && reg_addr_in == rssc_pkg::OFS_ERR && q_cnt_ff != '0;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      q_rd_ff <= '0;
      q_cnt_ff <= '0;
    end else if (pop) begin
      q_rd_ff <= qidx(q_rd_ff, 4'h1);
      q_cnt_ff <= q_cnt_ff - 4'h1;
    end else if (push && q_cnt_ff != QD) begin
      q_cnt_ff <= q_cnt_ff + 4'h1;
    end
  end

  // Full queue: newest discarded, final slot marks the overflow
  always_ff @(posedge core_clk_in) begin
    if (push && q_cnt_ff != QD) begin
      q_mem_ff[qidx(q_rd_ff, q_cnt_ff)] <= push_code;
    end else if (push) begin
      q_mem_ff[qidx(q_rd_ff, QD - 4'h1)] <= rssc_pkg::ERR_OVERFLOW;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      peek_ff <= '0;
    end else if (wr_at(rssc_pkg::OFS_PEEK)) begin
      peek_ff <= reg_wdata_in[3:0];
    end
  end

  // ------------------------------------------------------------------
  // Password and command gating
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pass_ff <= PASS_RST;
      prot_ff <= 1'b0;
    end else begin
      if (wr_at(rssc_pkg::OFS_PSTORE)) pass_ff <= reg_wdata_in;
      if (wr_at(rssc_pkg::OFS_PTRY) && reg_wdata_in == pass_ff) prot_ff <= 1'b1;
    end
  end

  // One-cycle outcome pulses
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      prot_cmd_go_out <= 1'b0;
      legacy_accept_out <= 1'b0;
      exec_err_out <= 1'b0;
    end else begin
      prot_cmd_go_out <= wr_at(rssc_pkg::OFS_PCMD) && prot_ff;
      legacy_accept_out <= wr_at(rssc_pkg::OFS_LEGACY) && cfg_ff.compat;
      exec_err_out <= push && !wr_at(rssc_pkg::OFS_ERR);
    end
  end

  // ------------------------------------------------------------------
  // Front panel, remote and lockout
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      knob_meta_ff <= 1'b0;
      knob_sync_ff <= 1'b0;
      knob_old_ff <= 1'b0;
      dip_meta_ff <= 1'b0;
      dip_sync_ff <= 1'b0;
      kept_meta_ff <= 1'b0;
      kept_sync_ff <= 1'b0;
    end else begin
      knob_meta_ff <= knobs_both_in;
      knob_sync_ff <= knob_meta_ff;
      knob_old_ff <= knob_sync_ff;
      dip_meta_ff <= dip5_on_in;
      dip_sync_ff <= dip_meta_ff;
      kept_meta_ff <= lock_kept_in;
      kept_sync_ff <= kept_meta_ff;
    end
  end
  assign knob_rise = knob_sync_ff && !knob_old_ff;

  // Straps settle through the synchronisers before being caught
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      init_ff <= '0;
    end else if (init_ff != rssc_pkg::INIT_WAIT) begin
      init_ff <= init_ff + 2'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      lock_ff <= 1'b0;
    end else if (init_ff == rssc_pkg::INIT_WAIT - 2'h1) begin
      lock_ff <= kept_sync_ff && dip_sync_ff;
    end else if (gpib_msg_valid_in && gpib_msg_in == rssc_pkg::MSG_LOCKOUT) begin
      lock_ff <= 1'b1;
    end else if (wr_at(rssc_pkg::OFS_LOCK)) begin
      lock_ff <= reg_wdata_in[0];
    end
  end

  // Any access sets remote; set wins over the knob gesture
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      remote_ff <= 1'b0;
    end else if (reg_wr_in || reg_rd_in) begin
      remote_ff <= 1'b1;
    end else if (knob_rise && !lock_ff) begin
      remote_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      panel_enable_out <= 1'b1;
      remote_out <= 1'b0;
      lockout_display_code_out <= 1'b0;
    end else begin
      panel_enable_out <= !remote_ff && !lock_ff;
      remote_out <= remote_ff || lock_ff;
      lockout_display_code_out <= lock_ff;
    end
  end

  // ------------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= '0;
      unique case (reg_addr_in)
        rssc_pkg::OFS_CFG: reg_rdata_out <= 16'(cfg_ff);
        rssc_pkg::OFS_STAT: reg_rdata_out <= {q_cnt_ff, 5'h00, sw_pend_ff,
          rx_full_ff, paused_ff, prot_ff, remote_ff, lock_ff, echo_act_ff};
        rssc_pkg::OFS_RATE: reg_rdata_out <= rssc_pkg::baud_rate(cfg_ff.baud);
        rssc_pkg::OFS_ERR: if (q_cnt_ff != '0) begin
          reg_rdata_out <= q_mem_ff[q_rd_ff];
        end
        rssc_pkg::OFS_PEEK: if (peek_ff < q_cnt_ff) begin
          reg_rdata_out <= q_mem_ff[qidx(q_rd_ff, peek_ff)];
        end
        rssc_pkg::OFS_LOCK: reg_rdata_out <= {15'h0000, lock_ff};
        rssc_pkg::OFS_PTRY: reg_rdata_out <= {15'h0000, prot_ff};
        rssc_pkg::OFS_RXD: reg_rdata_out <= {8'h00, rx_hold_ff};
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end
endmodule

// ===== common/rssc_pkg.sv
// Shared constants and types for the remote serial system command block
package rssc_pkg;
  // --------------------------------------------------------------------
  // Clock and serial timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam logic [15:0] RATE_19200 = 16'h4B00;
  localparam logic [15:0] RATE_9600 = 16'h2580;
  localparam logic [15:0] RATE_4800 = 16'h12C0;
  localparam logic [15:0] RATE_2400 = 16'h0960;
  localparam logic [3:0] RX_LAST_BIT = 4'h9;
  localparam logic [3:0] TX_LAST_BIT = 4'h9;
  localparam logic [1:0] INIT_WAIT = 2'h3;
  // --------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_ERR = 8'h0C;
  localparam logic [7:0] OFS_PEEK = 8'h10;
  localparam logic [7:0] OFS_LOCK = 8'h14;
  localparam logic [7:0] OFS_PSTORE = 8'h18;
  localparam logic [7:0] OFS_PTRY = 8'h1C;
  localparam logic [7:0] OFS_PCMD = 8'h20;
  localparam logic [7:0] OFS_DONE = 8'h24;
  localparam logic [7:0] OFS_LEGACY = 8'h28;
  localparam logic [7:0] OFS_TXD = 8'h2C;
  localparam logic [7:0] OFS_RXD = 8'h30;
  localparam logic [7:0] OFS_IRST = 8'h34;
  // --------------------------------------------------------------------
  // Codes and characters
  // --------------------------------------------------------------------
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_OVERFLOW = 16'hFEA2;
  localparam logic [15:0] ERR_CONFLICT = 16'hFF23;
  localparam logic [15:0] ERR_PROTECTED = 16'hFF35;
  localparam logic [7:0] CH_TERM = 8'h0A;
  localparam logic [7:0] CH_PROMPT = 8'h3E;
  localparam logic [7:0] CH_RESUME = 8'h11;
  localparam logic [7:0] CH_PAUSE = 8'h13;
  localparam logic [7:0] MSG_LOCKOUT = 8'h11;
  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef struct packed {
    logic compat;
    logic prompt;
    logic pace;
    logic txen;
    logic echo;
    logic [1:0] baud;
  } rssc_cfg_t;
  localparam int CFG_W = $bits(rssc_cfg_t);
  localparam rssc_cfg_t CFG_RST = '{compat: 1'b1, prompt: 1'b0, pace: 1'b0,
                                    txen: 1'b1, echo: 1'b0, baud: 2'h0};
  typedef enum logic {LNK_IDLE, LNK_BUSY} rssc_lnk_t;
  // Rate selector to baud figure
  function automatic logic [15:0] baud_rate(input logic [1:0] sel);
    unique case (sel)
      2'h0: baud_rate = RATE_19200;
      2'h1: baud_rate = RATE_9600;
      2'h2: baud_rate = RATE_4800;
      default: baud_rate = RATE_2400;
    endcase
  endfunction
  // Rate selector to bit period in clocks
  function automatic logic [15:0] baud_div(input logic [1:0] sel);
    baud_div = 16'(CLK_HZ / int'(baud_rate(sel)));
  endfunction
endpackage

// ===== verilog/rssc_uart.sv
// Serial character transmitter and receiver, 8N1 framing
`timescale 1ns/10ps
module rssc_uart (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Bit period in clocks
  input wire logic [15:0] bit_div_in,
  // Serial pins
  input wire logic rx_pin_in,
  output logic tx_pin_out,
  // Transmit stream
  input wire logic [7:0] tx_char_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // Receive stream
  output logic [7:0] rx_char_out,
  output logic rx_valid_out
);
  rssc_pkg::rssc_lnk_t tx_st_ff;
  rssc_pkg::rssc_lnk_t rx_st_ff;
  logic [15:0] tx_cnt_ff;
  logic [15:0] rx_cnt_ff;
  logic [9:0] tx_sh_ff;
  logic [3:0] tx_bits_ff;
  logic [3:0] rx_bits_ff;
  logic [7:0] rx_sh_ff;
  logic rx_meta_ff;
  logic rx_sync_ff;

  // Pin is asynchronous: two flops before use
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end else begin
      rx_meta_ff <= rx_pin_in;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  assign tx_ready_out = (tx_st_ff == rssc_pkg::LNK_IDLE);
  assign tx_pin_out = tx_sh_ff[0]; // Idles high

  // ------------------------------------------------------------------
  // Transmit: start, eight data bits LSB first, stop
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tx_st_ff <= rssc_pkg::LNK_IDLE;
      tx_sh_ff <= '1;
      tx_cnt_ff <= '0;
      tx_bits_ff <= '0;
    end else begin
      unique case (tx_st_ff)
        rssc_pkg::LNK_IDLE: if (tx_valid_in) begin
          tx_sh_ff <= {1'b1, tx_char_in, 1'b0};
          tx_cnt_ff <= bit_div_in - 16'h0001;
          tx_bits_ff <= rssc_pkg::TX_LAST_BIT;
          tx_st_ff <= rssc_pkg::LNK_BUSY;
        end
        rssc_pkg::LNK_BUSY: if (tx_cnt_ff != '0) begin
          tx_cnt_ff <= tx_cnt_ff - 16'h0001;
        end else if (tx_bits_ff == '0) begin
          tx_st_ff <= rssc_pkg::LNK_IDLE;
        end else begin
          tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
          tx_bits_ff <= tx_bits_ff - 4'h1;
          tx_cnt_ff <= bit_div_in - 16'h0001;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Receive: sample mid-bit, drop frames with a bad start or stop
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_st_ff <= rssc_pkg::LNK_IDLE;
      rx_cnt_ff <= '0;
      rx_bits_ff <= '0;
      rx_sh_ff <= '0;
      rx_char_out <= '0;
      rx_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      unique case (rx_st_ff)
        rssc_pkg::LNK_IDLE: if (!rx_sync_ff) begin
          rx_cnt_ff <= {1'b0, bit_div_in[15:1]};
          rx_bits_ff <= rssc_pkg::RX_LAST_BIT;
          rx_st_ff <= rssc_pkg::LNK_BUSY;
        end
        rssc_pkg::LNK_BUSY: if (rx_cnt_ff != '0) begin
          rx_cnt_ff <= rx_cnt_ff - 16'h0001;
        end else begin
          rx_cnt_ff <= bit_div_in - 16'h0001;
          rx_bits_ff <= rx_bits_ff - 4'h1;
          if (rx_bits_ff == rssc_pkg::RX_LAST_BIT) begin
            if (rx_sync_ff) rx_st_ff <= rssc_pkg::LNK_IDLE; // Glitch
          end else if (rx_bits_ff == '0) begin
            rx_st_ff <= rssc_pkg::LNK_IDLE;
            rx_char_out <= rx_sh_ff;
            rx_valid_out <= rx_sync_ff;
          end else begin
            rx_sh_ff <= {rx_sync_ff, rx_sh_ff[7:1]};
          end
        end
      endcase
    end
  end
endmodule

// ===== bench/rssc_ctrl_monitor.sv
// Port checker for the serial command controller
`timescale 1ns/10ps
module rssc_ctrl_monitor (
  // Clock, reset and register port
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  // Panel state and command outcomes
  input wire logic panel_enable_out,
  input wire logic remote_out,
  input wire logic lockout_display_code_out,
  input wire logic prot_cmd_go_out,
  input wire logic legacy_accept_out,
  input wire logic exec_err_out
);
  // ----------
  // Assertions
  // ----------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic w_pt, w_pc, w_lg, w_lk;
  // Write strobes decoded per register
  assign w_pt = reg_wr_in && reg_addr_in == rssc_pkg::OFS_PTRY;
  assign w_pc = reg_wr_in && reg_addr_in == rssc_pkg::OFS_PCMD;
  assign w_lg = reg_wr_in && reg_addr_in == rssc_pkg::OFS_LEGACY;
  assign w_lk = reg_wr_in && reg_addr_in == rssc_pkg::OFS_LOCK;
  property p_rd; !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000; endproperty
  a_rd: assert property (p_rd) else $error("read data outside its slot");
  property p_rem; (reg_wr_in || reg_rd_in) |-> ##[1:2] remote_out; endproperty
  a_rem: assert property (p_rem) else $error("access left unit local");
  property p_rpan; remote_out |-> !panel_enable_out; endproperty
  a_rpan: assert property (p_rpan) else $error("panel active in remote");
  property p_lpan; lockout_display_code_out |-> remote_out && !panel_enable_out; endproperty
  a_lpan: assert property (p_lpan) else $error("panel active in lockout");
  property p_unl; $fell(lockout_display_code_out) |-> $past(w_lk, 2); endproperty
  a_unl: assert property (p_unl) else $error("lockout left without unlock");
  property p_err; exec_err_out |-> $past(w_pt || w_pc); endproperty
  a_err: assert property (p_err) else $error("stray execution error");
  property p_go; prot_cmd_go_out |-> $past(w_pc) && !exec_err_out; endproperty
  a_go: assert property (p_go) else $error("stray protected command");
  property p_leg; legacy_accept_out |-> $past(w_lg); endproperty
  a_leg: assert property (p_leg) else $error("stray legacy accept");
endmodule
bind rssc_ctrl rssc_ctrl_monitor rssc_ctrl_monitor_i (.core_clk_in(core_clk_in),
  .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .panel_enable_out(panel_enable_out), .remote_out(remote_out),
  .lockout_display_code_out(lockout_display_code_out), .prot_cmd_go_out(prot_cmd_go_out),
  .legacy_accept_out(legacy_accept_out), .exec_err_out(exec_err_out));

// ===== bench/rssc_host.sv
// Host terminal model on the serial lines
`timescale 1ns/10ps
module rssc_host #(
  parameter int BIT_CLKS = 2083
) (
  // Clock and serial lines
  input wire logic core_clk_in,
  input wire logic dev_tx_in,
  output logic dev_rx_out
);
  initial dev_rx_out = 1'b1;
  // One frame, start, LSB first, stop; line rests at mark level
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      dev_rx_out <= f[i];
      repeat (BIT_CLKS) @(posedge core_clk_in);
    end
  endtask
  // Bounded wait for a start bit, then mid-cell sampling
  task automatic get(output logic [7:0] c, output logic ok);
    int n;
    n = 0;
    while (dev_tx_in !== 1'b0 && n < 50000) begin
      @(posedge core_clk_in);
      n++;
    end
    repeat (BIT_CLKS / 2) @(posedge core_clk_in);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge core_clk_in);
      if (i < 8) c[i] = dev_tx_in;
    end
    ok = n < 50000 && dev_tx_in === 1'b1;
  endtask
endmodule

// ===== bench/test_rssc_ctrl.sv
// Self-checking bench for the serial command controller
`timescale 1ns/10ps
module test_rssc_ctrl;
  // ----------------
  // Signals and DUT
  // ----------------
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr = 1'b0, rd = 1'b0, gpib = 1'b0, mv = 1'b0, knobs = 1'b0;
  logic [7:0] addr = 8'h00, msg = 8'h00, n_err = 8'h00, n_go = 8'h00, n_leg = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic rxd, txd, panel, remote, lockd, go, leg, err;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [15:0] rates [4] = '{16'h4B00, 16'h2580, 16'h12C0, 16'h0960};
  // 40 MHz clock
  always #12.5 core_clk_in = ~core_clk_in;
  // Outcome pulses are one cycle wide, so count them as they pass
  always @(posedge core_clk_in) begin
    if (go === 1'b1) n_go <= n_go + 8'h01;
    if (leg === 1'b1) n_leg <= n_leg + 8'h01;
    if (err === 1'b1) n_err <= n_err + 8'h01;
  end
  rssc_ctrl #(.QDEPTH(15), .PASS_RST(16'h0000)) rssc_ctrl_i (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_from_gpib_in(gpib), .reg_rdata_out(rdata),
    .ser_rx_in(rxd), .ser_tx_out(txd), .gpib_msg_valid_in(mv), .gpib_msg_in(msg),
    .knobs_both_in(knobs), .dip5_on_in(1'b0), .lock_kept_in(1'b0), .panel_enable_out(panel),
    .remote_out(remote), .lockout_display_code_out(lockd), .prot_cmd_go_out(go),
    .legacy_accept_out(leg), .exec_err_out(err));
  rssc_host rssc_host_i (.core_clk_in(core_clk_in), .dev_tx_in(txd), .dev_rx_out(rxd));
  // ------
  // Tasks
  // ------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Write then one idle cycle, so strobes never get two drivers in a step
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge core_clk_in);
  endtask
  task automatic knob();
    knobs <= 1'b1;
    repeat (8) @(posedge core_clk_in);
    knobs <= 1'b0;
    repeat (6) @(posedge core_clk_in);
  endtask
  // Echo starts before our stop bit ends, so send and listen together
  task automatic echo_chk(input logic [7:0] c);
    logic [7:0] r;
    logic ok;
    fork
      rssc_host_i.send(c);
      rssc_host_i.get(r, ok);
    join
    chk({8'h00, r}, {8'h00, c});
    if (ok !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  // ---------
  // Sequence
  // ---------
  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    rd_chk(8'h00, 16'h0048);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h00, 16'h0048 | 16'(i));
      rd_chk(8'h08, rates[i]);
    end
    wr_reg(8'h00, 16'h007C);
    wr_reg(8'h34, 16'h0000);
    rd_chk(8'h00, 16'h007C);
    wr_reg(8'h00, 16'h0074);
    wr_reg(8'h00, 16'h007C);
    rd_chk(8'h00, 16'h0074);
    gpib <= 1'b1;
    wr_reg(8'h00, 16'h007C);
    gpib <= 1'b0;
    rd_chk(8'h00, 16'h007C);
    wr_reg(8'h28, 16'h0000);
    wr_reg(8'h00, 16'h000C);
    wr_reg(8'h28, 16'h0000);
    chk(16'(n_leg), 16'h0001);
    for (int i = 0; i < 16; i++) begin
      wr_reg(8'h0C, 16'h0100 + 16'(i));
    end
    wr_reg(8'h10, 16'h0000);
    rd_chk(8'h10, 16'h0100);
    wr_reg(8'h10, 16'h000F);
    rd_chk(8'h10, 16'h0000);
    for (int i = 0; i < 14; i++) begin
      rd_chk(8'h0C, 16'h0100 + 16'(i));
    end
    rd_chk(8'h0C, 16'hFEA2);
    rd_chk(8'h0C, 16'h0000);
    wr_reg(8'h20, 16'h0000);
    rd_chk(8'h0C, 16'hFF35);
    wr_reg(8'h1C, 16'h1234);
    rd_chk(8'h0C, 16'hFF23);
    wr_reg(8'h1C, 16'h0000);
    rd_chk(8'h1C, 16'h0001);
    wr_reg(8'h20, 16'h0000);
    @(posedge core_clk_in);
    chk({n_err, n_go}, 16'h0201);
    knob();
    chk({14'h0, remote, panel}, 16'h0001);
    rd_chk(8'h14, 16'h0000);
    @(posedge core_clk_in);
    chk({14'h0, remote, panel}, 16'h0002);
    mv <= 1'b1;
    msg <= 8'h11;
    @(posedge core_clk_in);
    mv <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    knob();
    chk({13'h0, lockd, remote, panel}, 16'h0006);
    rd_chk(8'h14, 16'h0001);
    wr_reg(8'h14, 16'h0000);
    rd_chk(8'h14, 16'h0000);
    wr_reg(8'h00, 16'h0008);
    echo_chk(8'h41);
    echo_chk(8'h0A);
    rd_chk(8'h04, 16'h002C);
    rd_chk(8'h30, 16'h000A);
    finish_test();
  end
endmodule
